// ==== logic/ncpu_execute.sv ====
// Fetch, decode and execute core for part of a 4-bit CPU instruction set
//
// Functional notes
// - Carry-set branch: two bytes, adds signed offset only when carry is one.
// - Absolute jump loads PC with opcode low nibble joined to second byte.
// - Bit-clear branch tests pointer-addressed nibble bit, memory left untouched.
// - Carry-clear branch: two bytes, branches when carry zero, carry untouched.
// - Relative branches add signed offset to PC already past both bytes.
// - Indirect moves: store accumulator, load accumulator, load pointer low nibble.
// - Immediate loads of accumulator, pointer high and pointer low nibble.
// - Special register read into accumulator and write from accumulator.
// - Store accumulator then decrement pointer pair, one instruction.
// - Store accumulator or immediate then increment pointer pair.
// - All-zero opcode only advances the program counter.
// - OR memory nibble into accumulator, carry untouched.
// - XOR memory nibble into accumulator, carry untouched.
// - Pop loads accumulator from stack top then decrements stack pointer.
// - Push increments stack pointer then writes accumulator there.
// - Return restores PC nibbles high to low, decrementing stack each read.
// - Rotate right through carry: old carry to bit 3, bit 0 to carry.
// - Set the indirect function flag indexed by pointer low nibble.
// - Set-carry forces carry to one.
// - Set selected bit of pointer-addressed nibble, carry untouched.
// - Subtract memory from accumulator; carry clear on borrow, else set.
// - Exchange accumulator with pointer-addressed nibble, carry untouched.
// - Pointer pair is high:low nibble and wraps across eight bits.
`timescale 1ns/1ps
module ncpu_execute (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] progData,
    input wire logic [3:0] dataRdata,
    input wire logic [3:0] sfrRdata,
    output logic [ncpu_pkg::PC_W-1:0] progAddr,
    output ncpu_pkg::ncpu_dmem_req_s dataReq,
    output ncpu_pkg::ncpu_sfr_req_s sfrReq,
    output logic [3:0] accumulator,
    output logic carryFlag,
    output logic [7:0] dataPointerPair,
    output logic [7:0] stackPointerReg,
    output logic instrDone
);
    import ncpu_pkg::*;

    ncpu_state_e state_r;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pcNxt;
    logic [PC_W-1:0] progAddr_r;
    logic [7:0] opcode_r;
    logic [7:0] operand_r;
    logic [1:0] retCount_r;
    logic [NIB_W-1:0] accumulator_r;
    logic carry_r;
    logic [NIB_W-1:0] pointerHighNibble_r;
    logic [NIB_W-1:0] pointerLowNibble_r;
    logic [DADDR_W-1:0] stackPointerReg_r;
    ncpu_dmem_req_s dataReq_r;
    ncpu_sfr_req_s sfrReq_r;
    logic instrDone_r;

    logic [DADDR_W-1:0] pointerPair;
    logic [DADDR_W-1:0] pointerStepped;
    logic [DADDR_W-1:0] spInc;
    logic [DADDR_W-1:0] spDec;
    logic [PC_W-1:0] relTarget;
    logic [3:0] opHi;
    logic [3:0] opLo;
    logic exec;
    logic twoByte;
    logic memBit;
    logic [NIB_W-1:0] bitMask;
    logic retLast;

    assign opHi = opcode_r[7:4];
    assign opLo = opcode_r[3:0];
    assign exec = (state_r == S_EXEC);
    assign pointerPair = {pointerHighNibble_r, pointerLowNibble_r};
    assign relTarget = pc_r + {{4{operand_r[7]}}, operand_r};
    assign memBit = dataRdata[opcode_r[1:0]];
    assign bitMask = NIB_W'(1) << opcode_r[1:0];
    assign retLast = (retCount_r == RET_LAST);

    // Compare-and-branch groups are not executed here, but must still be
    // fetched as two bytes so the instruction stream stays aligned.
    assign twoByte = (progData[7:4] == HI_BRANCH && progData[3:0] != 4'h0)
        || progData[7:4] == HI_CMPL || progData[7:4] == HI_CMPI
        || progData[7:4] == HI_CMPD || progData[7:4] == HI_JMP;

    ncpu_step #(.W(DADDR_W)) ptrStep (
        .value(pointerPair),
        .down(opcode_r == OP_STDEC),
        .result(pointerStepped)
    );
    ncpu_step #(.W(DADDR_W)) spUp (
        .value(stackPointerReg_r),
        .down(1'b0),
        .result(spInc)
    );
    ncpu_step #(.W(DADDR_W)) spDown (
        .value(stackPointerReg_r),
        .down(1'b1),
        .result(spDec)
    );

    // Program counter after the executing instruction
    always_comb
    begin
        pcNxt = pc_r;
        if (opHi == HI_JMP)
        begin
            pcNxt = {opLo, operand_r};
        end
        else if (opcode_r == OP_JC && carry_r)
        begin
            pcNxt = relTarget;
        end
        else if (opcode_r == OP_JNC && !carry_r)
        begin
            pcNxt = relTarget;
        end
        else if (opcode_r[7:2] == GRP_JNB && !memBit)
        begin
            pcNxt = relTarget;
        end
        else if (opcode_r == OP_RET)
        begin
            case (retCount_r)
                2'h0: pcNxt[11:8] = dataRdata;
                2'h1: pcNxt[7:4] = dataRdata;
                default: pcNxt[3:0] = dataRdata;
            endcase
        end
    end

    // Sequencer: fetch opcode, optional operand, set up address, execute
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= S_FETCH;
            pc_r <= PC_RST;
            progAddr_r <= PC_RST;
            opcode_r <= OP_NOP;
            operand_r <= 8'h00;
            retCount_r <= 2'h0;
            instrDone_r <= 1'b0;
        end
        else
        begin
            instrDone_r <= 1'b0;
            case (state_r)
                S_FETCH:
                begin
                    opcode_r <= progData;
                    pc_r <= pc_r + PC_W'(1);
                    progAddr_r <= pc_r + PC_W'(1);
                    state_r <= twoByte ? S_OPERAND : S_ADDR;
                end
                S_OPERAND:
                begin
                    operand_r <= progData;
                    pc_r <= pc_r + PC_W'(1);
                    progAddr_r <= pc_r + PC_W'(1);
                    state_r <= S_ADDR;
                end
                S_ADDR:
                begin
                    retCount_r <= 2'h0;
                    state_r <= S_EXEC;
                end
                default:
                begin
                    pc_r <= pcNxt;
                    if (opcode_r == OP_RET && !retLast)
                    begin
                        retCount_r <= retCount_r + 2'h1;
                    end
                    else
                    begin
                        progAddr_r <= pcNxt;
                        instrDone_r <= 1'b1;
                        state_r <= S_FETCH;
                    end
                end
            endcase
        end
    end

    // Accumulator and carry
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            accumulator_r <= NIB_RST;
            carry_r <= 1'b0;
        end
        else if (exec)
        begin
            if (opcode_r == OP_LDIND || opcode_r == OP_XCH || opcode_r == OP_POP)
            begin
                accumulator_r <= dataRdata;
            end
            else if (opcode_r == OP_ORL)
            begin
                accumulator_r <= accumulator_r | dataRdata;
            end
            else if (opcode_r == OP_XRL)
            begin
                accumulator_r <= accumulator_r ^ dataRdata;
            end
            else if (opcode_r == OP_SUB)
            begin
                accumulator_r <= accumulator_r - dataRdata;
                carry_r <= !(accumulator_r < dataRdata);
            end
            else if (opcode_r == OP_RRC)
            begin
                accumulator_r <= {carry_r, accumulator_r[3:1]};
                carry_r <= accumulator_r[0];
            end
            else if (opcode_r == OP_SETC)
            begin
                carry_r <= 1'b1;
            end
            else if (opHi == HI_LDA)
            begin
                accumulator_r <= opLo;
            end
            else if (opHi == HI_SFRRD)
            begin
                accumulator_r <= sfrRdata;
            end
        end
    end

    // Data pointer pair
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pointerHighNibble_r <= NIB_RST;
            pointerLowNibble_r <= NIB_RST;
        end
        else if (exec)
        begin
            if (opHi == HI_LDH)
            begin
                pointerHighNibble_r <= opLo;
            end
            else if (opHi == HI_LDL)
            begin
                pointerLowNibble_r <= opLo;
            end
            else if (opcode_r == OP_LDLOW)
            begin
                pointerLowNibble_r <= dataRdata;
            end
            else if (opcode_r == OP_STINC || opcode_r == OP_STDEC || opHi == HI_STIMM)
            begin
                // The write still uses the latched old address
                {pointerHighNibble_r, pointerLowNibble_r} <= pointerStepped;
            end
        end
    end

    // Stack pointer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stackPointerReg_r <= SP_RST;
        end
        else if (exec)
        begin
            if (opcode_r == OP_PUSH)
            begin
                stackPointerReg_r <= spInc;
            end
            else if (opcode_r == OP_POP || opcode_r == OP_RET)
            begin
                stackPointerReg_r <= spDec;
            end
        end
    end

    // Data memory request; the write lands on the edge after execute
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dataReq_r <= '0;
        end
        else
        begin
            dataReq_r.we <= 1'b0;
            if (state_r == S_ADDR)
            begin
                if (opcode_r == OP_PUSH)
                begin
                    dataReq_r.addr <= spInc;
                end
                else if (opcode_r == OP_POP || opcode_r == OP_RET)
                begin
                    dataReq_r.addr <= stackPointerReg_r;
                end
                else
                begin
                    dataReq_r.addr <= pointerPair;
                end
            end
            else if (exec)
            begin
                if (opcode_r == OP_RET)
                begin
                    dataReq_r.addr <= spDec;
                end
                else if (opcode_r == OP_STIND || opcode_r == OP_STINC
                    || opcode_r == OP_STDEC || opcode_r == OP_PUSH
                    || opcode_r == OP_XCH)
                begin
                    dataReq_r.we <= 1'b1;
                    dataReq_r.wdata <= accumulator_r;
                end
                else if (opHi == HI_STIMM)
                begin
                    dataReq_r.we <= 1'b1;
                    dataReq_r.wdata <= opLo;
                end
                else if (opcode_r[7:2] == GRP_SETBIT)
                begin
                    dataReq_r.we <= 1'b1;
                    dataReq_r.wdata <= dataRdata | bitMask;
                end
            end
        end
    end

    // Special register request and indirect flag set
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sfrReq_r <= '0;
        end
        else
        begin
            sfrReq_r.we <= 1'b0;
            sfrReq_r.flagSet <= 1'b0;
            if (state_r == S_ADDR)
            begin
                sfrReq_r.addr <= opLo;
            end
            else if (exec && opHi == HI_SFRWR)
            begin
                sfrReq_r.we <= 1'b1;
                sfrReq_r.wdata <= accumulator_r;
            end
            else if (exec && opcode_r == OP_SETF)
            begin
                sfrReq_r.flagSet <= 1'b1;
                sfrReq_r.flagIdx <= pointerLowNibble_r;
            end
        end
    end

    assign progAddr = progAddr_r;
    assign dataReq = dataReq_r;
    assign sfrReq = sfrReq_r;
    assign accumulator = accumulator_r;
    assign carryFlag = carry_r;
    assign dataPointerPair = pointerPair;
    assign stackPointerReg = stackPointerReg_r;
    assign instrDone = instrDone_r;

    property p_jc_taken;
        @(posedge clk) disable iff (rst)
        (exec && opcode_r == OP_JC && carry_r) |=> (pc_r == $past(relTarget));
    endproperty
    a_jc_taken: assert property (p_jc_taken) else $error("carry-set branch missed");

    property p_jnc;
        @(posedge clk) disable iff (rst)
        (exec && opcode_r == OP_JNC) |=> (carry_r == $past(carry_r))
            && (pc_r == ($past(carry_r) ? $past(pc_r) : $past(relTarget)));
    endproperty
    a_jnc: assert property (p_jnc) else $error("carry-clear branch wrong");

    property p_jmp;
        @(posedge clk) disable iff (rst)
        (exec && opHi == HI_JMP) |=> (progAddr == $past({opLo, operand_r})) && instrDone;
    endproperty
    a_jmp: assert property (p_jmp) else $error("absolute jump target wrong");

    property p_jnb_no_write;
        @(posedge clk) disable iff (rst)
        (exec && opcode_r[7:2] == GRP_JNB) |=> !dataReq.we
            && (pc_r == ($past(memBit) ? $past(pc_r) : $past(relTarget)));
    endproperty
    a_jnb_no_write: assert property (p_jnb_no_write) else $error("bit branch wrong");

    property p_pop;
        @(posedge clk) disable iff (rst)
        (exec && opcode_r == OP_POP) |=> (accumulator == $past(dataRdata))
            && (stackPointerReg == $past(stackPointerReg) - 8'h01);
    endproperty
    a_pop: assert property (p_pop) else $error("pop result wrong");

    property p_push;
        @(posedge clk) disable iff (rst)
        (state_r == S_ADDR && opcode_r == OP_PUSH) |=> ##1 dataReq.we
            && (dataReq.addr == stackPointerReg) && (dataReq.wdata == accumulator);
    endproperty
    a_push: assert property (p_push) else $error("push write wrong");

    property p_ret_three;
        @(posedge clk) disable iff (rst)
        (state_r == S_ADDR && opcode_r == OP_RET) |=> exec [*3] ##1
            (state_r == S_FETCH && stackPointerReg == $past(stackPointerReg, 4) - 8'h03);
    endproperty
    a_ret_three: assert property (p_ret_three) else $error("return pops wrong");

    property p_rrc;
        @(posedge clk) disable iff (rst)
        (exec && opcode_r == OP_RRC) |=> (carryFlag == $past(accumulator[0]))
            && (accumulator == {$past(carryFlag), $past(accumulator[3:1])});
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate through carry wrong");

    property p_sub_carry;
        @(posedge clk) disable iff (rst)
        (exec && opcode_r == OP_SUB) |=> (carryFlag == ($past(accumulator) >= $past(dataRdata)));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

    property p_store_dec;
        @(posedge clk) disable iff (rst)
        (exec && opcode_r == OP_STDEC) |=> dataReq.we
            && (dataReq.addr == $past(dataPointerPair))
            && (dataPointerPair == $past(dataPointerPair) - 8'h01);
    endproperty
    a_store_dec: assert property (p_store_dec) else $error("store-decrement wrong");

    property p_nop;
        @(posedge clk) disable iff (rst)
        (exec && opcode_r == OP_NOP) |=> $stable(accumulator) && $stable(carryFlag)
            && $stable(dataPointerPair) && $stable(stackPointerReg) && !dataReq.we;
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");

endmodule

// ==== pkg/ncpu_pkg.sv ====
// Shared constants, opcodes, states and carrier structs of the nibble CPU execute block
package ncpu_pkg;

    localparam int PC_W = 12;
    localparam int DADDR_W = 8;
    localparam int NIB_W = 4;

    localparam logic [PC_W-1:0] PC_RST = 12'h000;
    localparam logic [DADDR_W-1:0] SP_RST = 8'h00;
    localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
    localparam logic [1:0] RET_LAST = 2'h2;

    // Full one-byte opcodes
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_SETC = 8'h01;
    localparam logic [7:0] OP_PUSH = 8'h02;
    localparam logic [7:0] OP_POP = 8'h03;
    localparam logic [7:0] OP_SUB = 8'h0B;
    localparam logic [7:0] OP_ORL = 8'h0D;
    localparam logic [7:0] OP_XRL = 8'h0E;
    localparam logic [7:0] OP_RRC = 8'h0F;
    localparam logic [7:0] OP_LDIND = 8'h80;
    localparam logic [7:0] OP_XCH = 8'h81;
    localparam logic [7:0] OP_LDLOW = 8'h82;
    localparam logic [7:0] OP_STIND = 8'h83;
    localparam logic [7:0] OP_STINC = 8'h84;
    localparam logic [7:0] OP_STDEC = 8'h85;
    localparam logic [7:0] OP_SETF = 8'h87;
    localparam logic [7:0] OP_RET = 8'h90;
    localparam logic [7:0] OP_JNC = 8'h96;
    localparam logic [7:0] OP_JC = 8'h97;

    // Upper-nibble opcode groups, low nibble is the operand except in the branch group, where it selects the instruction
    localparam logic [3:0] HI_LDL = 4'h2;
    localparam logic [3:0] HI_LDH = 4'h3;
    localparam logic [3:0] HI_STIMM = 4'h4;
    localparam logic [3:0] HI_LDA = 4'h5;
    localparam logic [3:0] HI_SFRWR = 4'h6;
    localparam logic [3:0] HI_SFRRD = 4'h7;
    localparam logic [3:0] HI_BRANCH = 4'h9;
    localparam logic [3:0] HI_CMPL = 4'hA;
    localparam logic [3:0] HI_CMPI = 4'hC;
    localparam logic [3:0] HI_CMPD = 4'hD;
    localparam logic [3:0] HI_JMP = 4'hE;

    // Upper six bits of the bit-select opcodes
    localparam logic [5:0] GRP_SETBIT = 6'h23;
    localparam logic [5:0] GRP_JNB = 6'h26;

    typedef enum logic [1:0] {
        S_FETCH = 2'b00,
        S_OPERAND = 2'b01,
        S_ADDR = 2'b10,
        S_EXEC = 2'b11
    } ncpu_state_e;

    typedef struct packed {
        logic we;
        logic [DADDR_W-1:0] addr;
        logic [NIB_W-1:0] wdata;
    } ncpu_dmem_req_s;

    typedef struct packed {
        logic we;
        logic [NIB_W-1:0] addr;
        logic [NIB_W-1:0] wdata;
        logic flagSet;
        logic [NIB_W-1:0] flagIdx;
    } ncpu_sfr_req_s;

endpackage

// ==== logic/ncpu_step.sv ====
// Wrapping up/down-by-one stepper used for the pointer pair and the stack pointer
`timescale 1ns/1ps
module ncpu_step #(
    parameter int W = 8
) (
    input wire logic [W-1:0] value,
    input wire logic down,
    output logic [W-1:0] result
);
    // Plain modulo arithmetic gives the wrap on overflow and underflow
    assign result = down ? value - W'(1) : value + W'(1);
endmodule

// ==== tb/ncpu_mem_model.sv ====
// Program, data and special register memories facing the execute block
`timescale 1ns/1ps
module ncpu_mem_model (
    input wire logic clk,
    input wire logic [ncpu_pkg::PC_W-1:0] progAddr,
    output logic [7:0] progData,
    input wire ncpu_pkg::ncpu_dmem_req_s dataReq,
    output logic [3:0] dataRdata,
    input wire ncpu_pkg::ncpu_sfr_req_s sfrReq,
    output logic [3:0] sfrRdata
);
    import ncpu_pkg::*;
    logic [7:0] prog [4096];
    logic [3:0] dmem [256];
    logic [3:0] sfr [16];
    logic [3:0] lastFlag;
    // Reads are combinational, so a stale address shows at once in the answer
    assign progData = prog[progAddr];
    assign dataRdata = dmem[dataReq.addr];
    assign sfrRdata = sfr[sfrReq.addr];
    // Plain always: the bench preloads these arrays too
    always @(posedge clk)
    begin
        if (dataReq.we)
        begin
            dmem[dataReq.addr] <= dataReq.wdata;
        end
        if (sfrReq.we)
        begin
            sfr[sfrReq.addr] <= sfrReq.wdata;
        end
        if (sfrReq.flagSet)
        begin
            lastFlag <= sfrReq.flagIdx;
        end
    end
endmodule

// ==== tb/test_ncpu_execute.sv ====
// Self-checking bench running a short program through the execute block
`timescale 1ns/1ps
module test_ncpu_execute;
    import ncpu_pkg::*;
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] arg;
        logic [3:0] acc;
        logic [3:0] cf;
        logic [7:0] dp;
        logic [7:0] sp;
        logic [11:0] pc;
    } ncpu_row_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] progAddr;
    logic [7:0] progData;
    logic [3:0] dataRdata;
    logic [3:0] sfrRdata;
    ncpu_dmem_req_s dataReq;
    ncpu_sfr_req_s sfrReq;
    logic [3:0] accumulator;
    logic carryFlag;
    logic [7:0] dataPointerPair;
    logic [7:0] stackPointerReg;
    logic instrDone;
    int numErrors = 0;
    int totalChecks = 0;
    int cycles = 0;
    // Fields: opcode, second byte, acc, carry, pointer, stack, next pc
    logic [51:0] rows [39] = '{
        52'h55_00_5_0_00_00_001, 52'h31_00_5_0_10_00_002, 52'h22_00_5_0_12_00_003,
        52'h0D_00_D_0_12_00_004, 52'h0E_00_4_0_12_00_005, 52'h0B_00_B_0_12_00_006,
        52'h01_00_B_1_12_00_007, 52'h0F_00_D_1_12_00_008, 52'h0B_00_4_1_12_00_009,
        52'h97_02_4_1_12_00_00D, 52'h96_05_4_1_12_00_00F, 52'h81_00_9_1_12_00_010,
        52'h84_00_9_1_13_00_011, 52'h4A_00_9_1_14_00_012, 52'h85_00_9_1_13_00_013,
        52'h80_00_A_1_13_00_014, 52'h02_00_A_1_13_01_015, 52'h53_00_3_1_13_01_016,
        52'h02_00_3_1_13_02_017, 52'h03_00_3_1_13_01_018, 52'h03_00_A_1_13_00_019,
        52'h8E_00_A_1_13_00_01A, 52'h82_00_A_1_1E_00_01B, 52'h99_04_A_1_1E_00_021,
        52'h6A_00_A_1_1E_00_022, 52'h7B_00_6_1_1E_00_023, 52'h87_00_6_1_1E_00_024,
        52'h00_00_6_1_1E_00_025, 52'h3F_00_6_1_FE_00_026, 52'h2F_00_6_1_FF_00_027,
        52'h84_00_6_1_00_00_028, 52'h85_00_6_1_FF_00_029, 52'hE5_00_6_1_FF_00_500,
        52'h90_00_6_1_FF_FD_663, 52'h51_00_1_1_FF_FD_664, 52'h0B_00_B_0_FF_FD_665,
        52'h96_F9_B_0_FF_FD_660, 52'h00_00_B_0_FF_FD_661, 52'hE7_00_B_0_FF_FD_700
    };

    ncpu_execute ncpu_execute_i (
        .clk(clk),
        .rst(rst),
        .progData(progData),
        .dataRdata(dataRdata),
        .sfrRdata(sfrRdata),
        .progAddr(progAddr),
        .dataReq(dataReq),
        .sfrReq(sfrReq),
        .accumulator(accumulator),
        .carryFlag(carryFlag),
        .dataPointerPair(dataPointerPair),
        .stackPointerReg(stackPointerReg),
        .instrDone(instrDone)
    );

    ncpu_mem_model ncpu_mem_model_i (
        .clk(clk),
        .progAddr(progAddr),
        .progData(progData),
        .dataReq(dataReq),
        .dataRdata(dataRdata),
        .sfrReq(sfrReq),
        .sfrRdata(sfrRdata)
    );

    always #5 clk = ~clk;

    function automatic bit two_byte(logic [7:0] op);
        return (op[7:4] inside {4'h9, 4'hA, 4'hC, 4'hD, 4'hE}) && op != OP_RET;
    endfunction

    task automatic printVerdict();
        if (numErrors == 0 && totalChecks > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Counts falling edges until the done pulse, bounded so a hang cannot stall
    task automatic wait_done(output int n);
        n = 1;
        @(negedge clk);
        while (instrDone !== 1'b1 && n < 8)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            numErrors++;
            printVerdict();
        end
    end

    initial
    begin
        ncpu_row_s r;
        logic [11:0] a;
        int n;
        for (int i = 0; i < 4096; i++) ncpu_mem_model_i.prog[i] = 8'h00;
        for (int i = 0; i < 256; i++) ncpu_mem_model_i.dmem[i] = 4'h0;
        for (int i = 0; i < 16; i++) ncpu_mem_model_i.sfr[i] = 4'h0;
        ncpu_mem_model_i.dmem[8'h12] = 4'h9;
        ncpu_mem_model_i.dmem[8'hFE] = 4'h3;
        ncpu_mem_model_i.sfr[4'hB] = 4'h6;
        a = 12'h000;
        foreach (rows[i])
        begin
            r = rows[i];
            ncpu_mem_model_i.prog[a] = r.op;
            if (two_byte(r.op)) ncpu_mem_model_i.prog[a + 12'h001] = r.arg;
            a = r.pc;
        end
        repeat (5) @(negedge clk);
        rst = 1'b0;
        foreach (rows[i])
        begin
            r = rows[i];
            wait_done(n);
            check($sformatf("cycles %h", r.op), 16'(n), two_byte(r.op) ? 16'h4 : (r.op == OP_RET ? 16'h5 : 16'h3));
            check($sformatf("pc %h", r.op), 16'(progAddr), 16'(r.pc));
            check($sformatf("acc %h", r.op), 16'(accumulator), 16'(r.acc));
            check($sformatf("carry %h", r.op), 16'(carryFlag), 16'(r.cf[0]));
            check($sformatf("ptr %h", r.op), 16'(dataPointerPair), 16'(r.dp));
            check($sformatf("sp %h", r.op), 16'(stackPointerReg), 16'(r.sp));
        end
        check("m12", 16'(ncpu_mem_model_i.dmem[8'h12]), 16'h9);
        check("m13", 16'(ncpu_mem_model_i.dmem[8'h13]), 16'hE);
        check("m14", 16'(ncpu_mem_model_i.dmem[8'h14]), 16'h9);
        check("m01", 16'(ncpu_mem_model_i.dmem[8'h01]), 16'hA);
        check("m02", 16'(ncpu_mem_model_i.dmem[8'h02]), 16'h3);
        check("m1E", 16'(ncpu_mem_model_i.dmem[8'h1E]), 16'h0);
        check("mFF", 16'(ncpu_mem_model_i.dmem[8'hFF]), 16'h6);
        check("m00", 16'(ncpu_mem_model_i.dmem[8'h00]), 16'h6);
        check("sfrA", 16'(ncpu_mem_model_i.sfr[4'hA]), 16'hA);
        check("flag", 16'(ncpu_mem_model_i.lastFlag), 16'hE);
        // Reset in mid-run must drop all state and restart from address zero
        rst = 1'b1;
        @(negedge clk);
        check("rst pc", 16'(progAddr), 16'h0);
        check("rst state", 16'({accumulator, carryFlag, dataPointerPair, stackPointerReg}), 16'h0);
        check("rst strobes", 16'({dataReq.we, sfrReq.we, sfrReq.flagSet, instrDone}), 16'h0);
        rst = 1'b0;
        wait_done(n);
        check("restart acc", 16'(accumulator), 16'h5);
        check("restart pc", 16'(progAddr), 16'h1);
        printVerdict();
    end
endmodule
